// *** src/sca_map.vh ***
// constants for the serial character adapter timing block
`ifndef SCA_MAP_VH
`define SCA_MAP_VH
`define SCA_CLK_HZ 20000000
`define SCA_FRAME_BITS 11
`define SCA_DATA_BITS 8
`define SCA_OP_BITS 9
`define SCA_LOAD_BITS 2
`define SCA_DIV_W 20
`define SCA_BIT_W 4
`define SCA_RATE_W 4
`define SCA_CC_W 3
`define SCA_CC_EXC 3'h2
`define SCA_CC_DE 3'h3
`define SCA_CC_ATT 3'h4
`define SCA_CC_ATT_EXC 3'h6
`define SCA_CC_ATT_DE 3'h7
`define SCA_CC_NONE 3'h0
`define SCA_RX_RESET 8'hff
`endif

// *** src/sca_bit_tick.v ***
// bit-time tick generator from the selected rate code
`timescale 1ns/1ps
`include "sca_map.vh"
module sca_bit_tick (
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// control
	input wire i_restart,
	input wire [`SCA_RATE_W-1:0] i_rate,
	// tick
	output wire o_tick
);
	// cycles per bit time at 20 MHz; reserved codes fall back to 9600
	function [`SCA_DIV_W-1:0] sca_div;
		input [`SCA_RATE_W-1:0] r;
		begin
			case (r)
			4'h0: sca_div = 20'd181818;
			4'h4: sca_div = 20'd400000;
			4'h5: sca_div = 20'd200000;
			4'h6: sca_div = 20'd100000;
			4'h8: sca_div = 20'd266667;
			4'h9: sca_div = 20'd133333;
			4'ha: sca_div = 20'd66667;
			4'hb: sca_div = 20'd33333;
			4'hc: sca_div = 20'd16667;
			4'hd: sca_div = 20'd8333;
			4'he: sca_div = 20'd4167;
			default: sca_div = 20'd2083;
			endcase
		end
	endfunction
	reg [`SCA_DIV_W-1:0] cnt_q;
	wire [`SCA_DIV_W-1:0] top = sca_div(i_rate) - 20'h1;
	assign o_tick = (cnt_q == top) && !i_restart;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 20'h0;
		end else if (i_restart || o_tick || cnt_q > top) begin
			cnt_q <= 20'h0;
		end else begin
			cnt_q <= cnt_q + 20'h1;
		end
	end
endmodule // sca_bit_tick

// *** src/sca_adapter.v ***
// serial character adapter: transmit/receive timing and condition codes
`timescale 1ns/1ps
`include "sca_map.vh"
////////////////////////////////////////////////////////////////////////////
// Function
// - device end posted nine bit times after transmit starts
// - two bit time load window follows device end posting
// - write inside load window waits until window ends
// - write busy from write acceptance, including deferred wait
// - write after window expires starts transmit at once
// - transmit completion signalled with condition code 3
// - receive interrupt posted nine bit times after start bit
// - normal receive loads data register and posts attention
// - receive while unread character held runs overrun, code 2
// - held character stays readable during overrun
// - read still needed after accepting condition code 2, else the character stays unread
// - read within gap after code 2 makes next receive code 4
// - further read delay gives another overrun and code 2
// - normal plus overrun both completed report code 6
// - frame is start, eight data, two stop bits
// - exception presented before device end, which stays pending
// - overrun discards new character, keeps old one
module sca_adapter (
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// configuration
	input wire [`SCA_RATE_W-1:0] i_rate,
	// processor side
	input wire i_wr,
	input wire [`SCA_DATA_BITS-1:0] i_wr_data,
	input wire i_rd,
	input wire i_int_ack,
	output wire o_wr_busy,
	output wire o_int_req,
	output wire [`SCA_CC_W-1:0] o_cc,
	output wire [`SCA_DATA_BITS-1:0] o_rx_data,
	// serial line
	input wire i_rxd,
	output wire o_txd
);
	////////////////////////////////////////////////////////////////////
	localparam TX_IDLE = 2'h0;
	localparam TX_SEND = 2'h1;
	localparam TX_LOAD = 2'h2;
	localparam RX_IDLE = 1'b0;
	localparam RX_RUN = 1'b1;

	reg [1:0] tx_st_q;
	reg [`SCA_BIT_W-1:0] tx_bit_q;
	reg [10:0] tx_sh_q;
	reg [`SCA_DATA_BITS-1:0] tx_hold_q;
	reg tx_pend_q;
	reg de_q;
	reg rx_st_q;
	reg [`SCA_BIT_W-1:0] rx_bit_q;
	reg [`SCA_DATA_BITS-1:0] rx_sh_q;
	reg [`SCA_DATA_BITS-1:0] rx_data_q;
	reg rx_full_q;
	reg rx_read_q;
	reg rx_ovr_q;
	reg att_q;
	reg exc_q;
	reg rx_prev_q;
	reg [`SCA_CC_W-1:0] cc_q;
	reg ireq_q;

	wire tx_tick;
	wire rx_tick;
	wire tx_start = (tx_st_q == TX_IDLE) && tx_pend_q;
	sca_bit_tick u_tx_tick (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_restart(tx_start),
		.i_rate(i_rate),
		.o_tick(tx_tick)
	);
	// receive tick restarts on the start edge so bits land at the start of each cell
	wire rx_edge = (rx_st_q == RX_IDLE) && rx_prev_q && !i_rxd;
	sca_bit_tick u_rx_tick (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_restart(rx_edge),
		.i_rate(i_rate),
		.o_tick(rx_tick)
	);

	////////////////////////////////////////////////////////////////////
	// transmit: frame of 11 bits, device end after nine
	wire tx_done = (tx_st_q == TX_SEND) && tx_tick &&
		(tx_bit_q == `SCA_OP_BITS - 1);
	wire load_done = (tx_st_q == TX_LOAD) && tx_tick &&
		(tx_bit_q == `SCA_FRAME_BITS - 1);
	assign o_wr_busy = tx_pend_q || (tx_st_q == TX_SEND);
	assign o_txd = tx_sh_q[0];
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_st_q <= TX_IDLE;
			tx_bit_q <= 4'h0;
			tx_sh_q <= 11'h7ff;
			tx_hold_q <= 8'h00;
			tx_pend_q <= 1'b0;
		end else begin
			if (i_wr && !o_wr_busy) begin
				tx_pend_q <= 1'b1;
				tx_hold_q <= i_wr_data;
			end else if (tx_start) begin
				tx_pend_q <= 1'b0;
			end
			case (tx_st_q)
			TX_IDLE: begin
				if (tx_start) begin
					tx_st_q <= TX_SEND;
					tx_bit_q <= 4'h0;
					tx_sh_q <= {2'h3, tx_hold_q, 1'b0};
				end
			end
			TX_SEND: begin
				if (tx_tick) begin
					tx_bit_q <= tx_bit_q + 4'h1;
					tx_sh_q <= {1'b1, tx_sh_q[10:1]};
				end
				if (tx_done) begin
					tx_st_q <= TX_LOAD;
				end
			end
			TX_LOAD: begin
				// waits out both stop bits before the next start
				if (tx_tick) begin
					tx_bit_q <= tx_bit_q + 4'h1;
					tx_sh_q <= {1'b1, tx_sh_q[10:1]};
				end
				if (load_done) begin
					tx_st_q <= TX_IDLE;
				end
			end
			default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// receive: sample at start of each bit cell, post after nine bit times
	wire rx_done = (rx_st_q == RX_RUN) && rx_tick &&
		(rx_bit_q == `SCA_OP_BITS - 1);
	wire rx_mid = (rx_st_q == RX_RUN) && rx_tick;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_st_q <= RX_IDLE;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_data_q <= `SCA_RX_RESET;
			rx_full_q <= 1'b0;
			rx_read_q <= 1'b0;
			rx_ovr_q <= 1'b0;
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= i_rxd;
			if (i_rd) begin
				rx_read_q <= 1'b1;
			end
			case (rx_st_q)
			RX_IDLE: begin
				if (rx_edge) begin
					rx_st_q <= RX_RUN;
					rx_bit_q <= 4'h0;
					// overrun if held character never read
					rx_ovr_q <= rx_full_q && !rx_read_q && !i_rd;
				end
			end
			RX_RUN: begin
				if (rx_mid) begin
					rx_bit_q <= rx_bit_q + 4'h1;
					rx_sh_q <= {i_rxd, rx_sh_q[7:1]};
				end
				if (rx_done) begin
					rx_st_q <= RX_IDLE;
					if (!rx_ovr_q) begin
						rx_data_q <= rx_sh_q;
						rx_full_q <= 1'b1;
						rx_read_q <= 1'b0;
					end
				end
			end
			default: rx_st_q <= RX_IDLE;
			endcase
		end
	end
	assign o_rx_data = rx_data_q;

	////////////////////////////////////////////////////////////////////
	// pending conditions; posting wins over acceptance clear
	wire att_set = rx_done && !rx_ovr_q;
	wire exc_set = rx_done && rx_ovr_q;
	wire ack = i_int_ack && ireq_q;
	// clear only what the presented code carried; a later post survives
	wire clr_att = ack && cc_q[2];
	wire clr_exc = ack && cc_q[1] && !cc_q[0];
	wire ack_de = ack && cc_q[0];
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			att_q <= 1'b0;
			exc_q <= 1'b0;
			de_q <= 1'b0;
		end else begin
			att_q <= att_set || (att_q && !clr_att);
			exc_q <= exc_set || (exc_q && !clr_exc);
			de_q <= tx_done || (de_q && !ack_de);
		end
	end

	// code chosen from pending flags; exception outranks device end
	reg [`SCA_CC_W-1:0] cc_d;
	always @* begin
		cc_d = `SCA_CC_NONE;
		if (att_q && exc_q) begin
			cc_d = `SCA_CC_ATT_EXC;
		end else if (exc_q) begin
			cc_d = `SCA_CC_EXC;
		end else if (att_q && de_q) begin
			cc_d = `SCA_CC_ATT_DE;
		end else if (att_q) begin
			cc_d = `SCA_CC_ATT;
		end else if (de_q) begin
			cc_d = `SCA_CC_DE;
		end
	end
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cc_q <= `SCA_CC_NONE;
			ireq_q <= 1'b0;
		end else begin
			cc_q <= cc_d;
			ireq_q <= (cc_d != `SCA_CC_NONE) && !ack;
		end
	end
	assign o_int_req = ireq_q;
	assign o_cc = cc_q;
endmodule // sca_adapter

// *** test/sca_adapter_sva.sv ***
// assertion checker on the adapter ports
`timescale 1ns/1ps
module sca_chk (
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// watched ports
	input wire i_wr,
	input wire i_int_ack,
	input wire o_wr_busy,
	input wire o_int_req,
	input wire [2:0] o_cc,
	input wire [7:0] o_rx_data,
	input wire o_txd
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_BUSY_ON: assert property (i_wr && !o_wr_busy |=> o_wr_busy)
		else $error("busy not raised");
	AST_IDLE_HIGH: assert property (!o_wr_busy |-> o_txd)
		else $error("line low while idle");
	AST_DE_POST: assert property ($fell(o_wr_busy) |-> ##[1:3] o_int_req)
		else $error("no request after device end");
	AST_CC_SET: assert property (o_int_req |-> o_cc inside {2, 3, 4, 6, 7})
		else $error("bad condition code");
	AST_REQ_STAND: assert property (o_int_req && !i_int_ack |=> o_int_req)
		else $error("request dropped unaccepted");
	AST_ACK_DROP: assert property (o_int_req && i_int_ack |=> !o_int_req)
		else $error("request kept after accept");
	AST_RX_LOAD: assert property ($changed(o_rx_data)
		|-> ##[0:2] (o_int_req && o_cc[2]))
		else $error("data loaded without attention");
	AST_OVR_KEEP: assert property (o_int_req && o_cc == 3'h2
		|-> $stable(o_rx_data))
		else $error("held character lost");
	cover property (o_int_req && o_cc == 3'h2);
	cover property (o_int_req && o_cc == 3'h3);
	cover property (o_int_req && o_cc == 3'h4);
endmodule // sca_chk
bind sca_adapter sca_chk i_sca_chk (.i_clk, .i_rst_n, .i_wr, .i_int_ack,
	.o_wr_busy, .o_int_req, .o_cc, .o_rx_data, .o_txd);

// *** test/sca_term.sv ***
// terminal model driving the receive line
`timescale 1ns/1ps
module sca_term (
	// clock
	input wire i_clk,
	// serial line
	output logic o_rxd
);
	initial o_rxd = 1'b1;
	// two stop bits: next start two bit times after the post
	task send(input logic [7:0] b);
		logic [10:0] f;
		f = {2'b11, b, 1'b0};
		for (int k = 0; k < 11; k++) begin
			o_rxd <= f[k];
			repeat (2083) @(posedge i_clk);
		end
	endtask
endmodule // sca_term

// *** test/tb_sca_adapter.sv ***
// self-checking bench for the adapter
`timescale 1ns/1ps
module tb_sca_adapter;
	logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_int_ack = 0;
	logic [7:0] i_wr_data = 8'h00, d;
	wire o_wr_busy, o_int_req, o_txd, rxd;
	wire [2:0] o_cc;
	wire [7:0] o_rx_data;
	int error_cnt = 0, total_checks = 0, cyc = 0, t0, t1;
	logic [10:0] q[$];
	logic [10:0] e;
	// reserved rate code runs at 9600
	sca_adapter i_sca_adapter (.i_clk, .i_rst_n, .i_rate(4'hf), .i_wr,
		.i_wr_data, .i_rd, .i_int_ack, .o_wr_busy, .o_int_req, .o_cc,
		.o_rx_data, .i_rxd(rxd), .o_txd);
	sca_term i_sca_term (.i_clk, .o_rxd(rxd));
	initial forever #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			error_cnt++;
			finish_test();
		end
	end
	task chk(input logic [10:0] got, input logic [10:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [7:0] v);
		@(posedge i_clk) i_wr <= 1;
		i_wr_data <= v;
		@(posedge i_clk) i_wr <= 0;
		t0 = cyc;
		q.push_back(11'h3ff);
		#1 chk({10'h0, o_wr_busy}, 11'h1);
	endtask
	task wait_int;
		repeat (30000) begin
			@(posedge i_clk);
			if (o_int_req === 1'b1) break;
		end
	endtask
	task drain;
		repeat (30000) begin
			@(posedge i_clk);
			if (q.size() == 0 && o_int_req === 1'b0) break;
		end
	endtask
	task rx(input logic [2:0] c);
		d = $urandom;
		q.push_back({c, c == 3'h2 ? e[7:0] : d});
		i_sca_term.send(d);
	endtask
	////////////////////////////////////////////////////////////////////////
	// watcher: accept each request, compare against the oldest note
	initial forever begin
		@(posedge i_clk);
		if (o_int_req === 1'b1) begin
			e = q.size() ? q.pop_front() : 11'h0;
			chk({o_cc, o_rx_data}, e);
			i_int_ack <= 1;
			@(posedge i_clk) i_int_ack <= 0;
			@(posedge i_clk);
		end
	end
	initial begin
		void'($urandom(4058));
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1;
		wr($urandom);
		wait_int;
		t1 = cyc;
		chk({10'h0, t1 - t0 inside {[18740:18790]}}, 11'h1);
		repeat (3) @(posedge i_clk);
		wr($urandom);
		fork
			begin
				repeat (1000) @(posedge i_clk);
				#1 chk({10'h0, o_txd}, 11'h1);
				wait_int;
				chk({10'h0, cyc - t1 inside {[22900:22960]}}, 11'h1);
			end
			begin
				repeat (6300) @(posedge i_clk);
				rx(3'h4);
			end
		join
		$display("transmit test done");
		rx(3'h2);
		drain;
		@(posedge i_clk) i_rd <= 1;
		@(posedge i_clk) i_rd <= 0;
		e[7:0] = d;
		rx(3'h4);
		drain;
		$display("receive test done");
		finish_test();
	end
endmodule // tb_sca_adapter
